// [pbbp_defines.svh]
// constants of the pseudo-static ram burst link
`ifndef PBBP_DEFINES_SVH
`define PBBP_DEFINES_SVH
// clock and link timing
`define PBBP_CLK_MHZ 25
`define PBBP_DIV_STEP 3'h3
`define PBBP_MAX_LOW_US 4
`define PBBP_MAX_LOW_CYC (`PBBP_MAX_LOW_US * `PBBP_CLK_MHZ)
`define PBBP_LOW_MARGIN 16
`define PBBP_DPD_US 150
`define PBBP_DPD_CYC (`PBBP_DPD_US * `PBBP_CLK_MHZ)
`define PBBP_DPDX_US 10
`define PBBP_DPDX_CYC (`PBBP_DPDX_US * `PBBP_CLK_MHZ)
`define PBBP_PU_US 150
`define PBBP_PU_CYC (`PBBP_PU_US * `PBBP_CLK_MHZ)
// burst geometry
`define PBBP_BURST_LEN 3'h4
`define PBBP_ROW_BITS 4
`define PBBP_MEM_BITS 6
// bus_config_register fields
`define PBBP_LC_HI 13
`define PBBP_LC_LO 11
`define PBBP_WT_BIT 8
`define PBBP_OPM_BIT 15
`define PBBP_CFG_RESET 16'h1000
// register offsets
`define PBBP_REG_CTRL 8'h00
`define PBBP_REG_CONFIG 8'h04
`define PBBP_REG_ADDR 8'h08
`define PBBP_REG_WDATA 8'h0C
`define PBBP_REG_RDATA 8'h10
`define PBBP_REG_STATUS 8'h14
// control and status bits
`define PBBP_CTRL_GO 0
`define PBBP_CTRL_WRITE 1
`define PBBP_CTRL_SLEEP 2
`define PBBP_ST_ROW 4
`define PBBP_ST_TIME 5
`define PBBP_RESP_OKAY 2'h0
`define PBBP_RESP_SLVERR 2'h2
`endif

// [pbbp_pkg.sv]
// types shared by both ends of the burst link
`include "pbbp_defines.svh"
package pbbp_pkg;
  typedef enum logic [3:0] {
    DEV_IDLE = 4'h1,
    DEV_LAT = 4'h2,
    DEV_DATA = 4'h4,
    DEV_END = 4'h8
  } pbbp_dev_state_t;

  typedef enum logic [4:0] {
    CTL_PWR = 5'h01,
    CTL_IDLE = 5'h02,
    CTL_BURST = 5'h04,
    CTL_GAP = 5'h08,
    CTL_SLEEP = 5'h10
  } pbbp_ctl_state_t;

  typedef struct packed {
    pbbp_dev_state_t state;
    logic [2:0] clk_s;
    logic [1:0] sel_s;
    logic [1:0] adv_s;
    logic [1:0] oe_s;
    logic [1:0] we_s;
    logic [1:0][15:0] dq_s;
    logic [15:0] cfg;
    logic is_write;
    logic [15:0] addr;
    logic [2:0] lat;
    logic [2:0] words;
    logic wait_n;
    logic [15:0] dq;
    logic dq_oe;
    logic busy;
  } pbbp_dev_reg_t;

  typedef struct packed {
    pbbp_ctl_state_t state;
    logic [2:0] div;
    logic link_clk;
    logic sel_n;
    logic adv_n;
    logic oe_n;
    logic we_n;
    logic [15:0] dq;
    logic dq_oe;
    logic [1:0] wait_s;
    logic [1:0][15:0] dqin_s;
    logic [3:0] step_c;
    logic [2:0] words;
    logic go;
    logic dir;
    logic sleep_req;
    logic [15:0] cfg;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [1:0][15:0] fifo;
    logic [1:0] fcnt;
    logic [11:0] tmr;
    logic [7:0] low_cnt;
    logic row_stop;
    logic time_stop;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdat;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pbbp_ctl_reg_t;
endpackage

// [pbbp_if.sv]
// link between memory controller and pseudo-static ram
`timescale 1ns/10ps
interface pbbp_if;
  logic link_clk;
  logic select_n;
  logic address_valid_n;
  logic output_en_n;
  logic write_en_n;
  logic [15:0] ctl_dq;
  logic ctl_dq_oe;
  logic wait_n;
  logic [15:0] dev_dq;
  logic dev_dq_oe;
  logic [15:0] adq;

  // shared address/data wire, memory wins a clash
  assign adq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : 16'h0000);

  modport ctl (
    output link_clk, select_n, address_valid_n, output_en_n, write_en_n,
    output ctl_dq, ctl_dq_oe,
    input wait_n, adq
  );
  modport dev (
    input link_clk, select_n, address_valid_n, output_en_n, write_en_n,
    input adq,
    output wait_n, dev_dq, dev_dq_oe
  );
endinterface

// [pbbp_device.sv]
// memory end: burst responder with latency wait and row crossing
`timescale 1ns/10ps
`include "pbbp_defines.svh"
module pbbp_device (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // link
  pbbp_if.dev link,
  // user side
  input wire logic [15:0] bus_config_in,
  output logic busy_out
);
  pbbp_pkg::pbbp_dev_reg_t r;
  pbbp_pkg::pbbp_dev_reg_t next_r;
  logic [15:0] mem [0:(1 << `PBBP_MEM_BITS) - 1];
  logic mem_we;
  logic [`PBBP_MEM_BITS-1:0] mem_waddr;
  logic [15:0] mem_wdata;

  assign link.wait_n = r.wait_n;
  assign link.dev_dq = r.dq;
  assign link.dev_dq_oe = r.dq_oe;
  assign busy_out = r.busy;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic rise;
    logic [2:0] lc;
    logic row_end;
    logic last;
    rise = 1'b0;
    lc = 3'h0;
    row_end = 1'b0;
    last = 1'b0;
    next_r = r;
    mem_we = 1'b0;
    mem_waddr = r.addr[`PBBP_MEM_BITS-1:0];
    mem_wdata = r.dq_s[1];
    // first stage of each chain feeds only the second
    next_r.clk_s = {r.clk_s[1:0], link.link_clk};
    next_r.sel_s = {r.sel_s[0], link.select_n};
    next_r.adv_s = {r.adv_s[0], link.address_valid_n};
    next_r.oe_s = {r.oe_s[0], link.output_en_n};
    next_r.we_s = {r.we_s[0], link.write_en_n};
    next_r.dq_s = {r.dq_s[0], link.adq};
    next_r.cfg = bus_config_in;
    rise = r.clk_s[1] & ~r.clk_s[2];
    lc = r.cfg[`PBBP_LC_HI:`PBBP_LC_LO];
    row_end = &r.addr[`PBBP_ROW_BITS-1:0];
    last = (r.words + 3'h1) == `PBBP_BURST_LEN;
    if (r.sel_s[1]) begin
      // deselect releases the bus at once, no link edge needed
      next_r.state = pbbp_pkg::DEV_IDLE;
      next_r.wait_n = 1'b1;
      next_r.dq_oe = 1'b0;
    end else if (rise) begin
      if (!r.adv_s[1] && (r.state == pbbp_pkg::DEV_IDLE ||
          r.state == pbbp_pkg::DEV_END)) begin
        // a new access starts on address valid even with select held low
        next_r.state = pbbp_pkg::DEV_LAT;
        next_r.addr = r.dq_s[1];
        next_r.is_write = ~r.we_s[1];
        next_r.words = 3'h0;
        // code n gives n+1 clocks to first word; code 0 acts as 1
        next_r.lat = (lc == 3'h0) ? 3'h0 : lc - 3'h1;
        next_r.wait_n = 1'b0;
      end else begin
        unique case (r.state)
          pbbp_pkg::DEV_IDLE: begin
            next_r.wait_n = 1'b1;
          end
          pbbp_pkg::DEV_LAT: begin
            if (r.lat == 3'h0) begin
              next_r.state = pbbp_pkg::DEV_DATA;
              next_r.wait_n = 1'b1;
              next_r.dq = mem[r.addr[`PBBP_MEM_BITS-1:0]];
            end else begin
              next_r.lat = r.lat - 3'h1;
            end
          end
          pbbp_pkg::DEV_DATA: begin
            if (r.is_write) begin
              mem_we = 1'b1;
            end
            next_r.words = r.words + 3'h1;
            next_r.addr = r.addr + 16'h0001;
            if (last) begin
              // past the burst end: wait stays idle, data is driven as zero
              next_r.state = pbbp_pkg::DEV_END;
              next_r.wait_n = 1'b1;
              next_r.dq = 16'h0000;
            end else if (row_end) begin
              next_r.state = pbbp_pkg::DEV_LAT;
              next_r.lat = (lc == 3'h0) ? 3'h0 : lc - 3'h1;
              next_r.wait_n = 1'b0;
            end else begin
              next_r.dq = mem[next_r.addr[`PBBP_MEM_BITS-1:0]];
            end
          end
          pbbp_pkg::DEV_END: begin
            next_r.wait_n = 1'b1;
          end
        endcase
      end
      next_r.dq_oe = ~next_r.is_write & ~r.oe_s[1] &
        (next_r.state == pbbp_pkg::DEV_DATA ||
         next_r.state == pbbp_pkg::DEV_END);
    end
    next_r.busy = next_r.state != pbbp_pkg::DEV_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      r <= '0;
      r.state <= pbbp_pkg::DEV_IDLE;
      r.clk_s <= 3'h0;
      r.sel_s <= 2'h3;
      r.adv_s <= 2'h3;
      r.oe_s <= 2'h3;
      r.we_s <= 2'h3;
      r.cfg <= `PBBP_CFG_RESET;
      r.wait_n <= 1'b1;
    end else begin
      r <= next_r;
    end
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end
endmodule

// [pbbp_ctrl.sv]
// controller end: axi4-lite registers, link clock divider, burst driver
`timescale 1ns/10ps
`include "pbbp_defines.svh"
// Operation
// - wait stays idle past burst end
// - words past burst end are ignored
// - row end stop: raise select quickly
// - row crossing waits latency code cycles
// - burst write start waits latency code cycles
// - latency code sits in config bits 13:11
// - code n means n+1 clocks latency
// - select high right after last write word
// - give refresh chance within select low limit
// - select high between async and variable bursts
// - select may stay low for fixed reads
// - async op starts at address valid fall
// - select high gap between operations
// - respect power-up and deep sleep intervals
// - select low never beyond four microseconds
module pbbp_ctrl (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // axi4-lite write
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // axi4-lite read
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // configuration image for the memory
  output logic [15:0] config_out,
  // link
  pbbp_if.ctl link
);
  pbbp_pkg::pbbp_ctl_reg_t r;
  pbbp_pkg::pbbp_ctl_reg_t next_r;

  function automatic logic [15:0] merge16(input logic [15:0] old,
    input logic [31:0] wd, input logic [3:0] st);
    logic [15:0] m;
    m = old;
    if (st[0]) begin
      m[7:0] = wd[7:0];
    end
    if (st[1]) begin
      m[15:8] = wd[15:8];
    end
    return m;
  endfunction

  assign awready_out = r.awready;
  assign wready_out = r.wready;
  assign bresp_out = r.bresp;
  assign bvalid_out = r.bvalid;
  assign arready_out = r.arready;
  assign rdata_out = r.rdata;
  assign rresp_out = r.rresp;
  assign rvalid_out = r.rvalid;
  assign config_out = r.cfg;
  assign link.link_clk = r.link_clk;
  assign link.select_n = r.sel_n;
  assign link.address_valid_n = r.adv_n;
  assign link.output_en_n = r.oe_n;
  assign link.write_en_n = r.we_n;
  assign link.ctl_dq = r.dq;
  assign link.ctl_dq_oe = r.dq_oe;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic near;
    logic stall;
    logic step;
    logic stop;
    logic [3:0] k;
    logic [3:0] first;
    near = 1'b0;
    stall = 1'b0;
    step = 1'b0;
    stop = 1'b0;
    k = 4'h0;
    first = 4'h0;
    next_r = r;
    next_r.wait_s = {r.wait_s[0], link.wait_n};
    next_r.dqin_s = {r.dqin_s[0], link.adq};

    // register writes, taken in either order of address and data
    if (awvalid_in && r.awready) begin
      next_r.aw_have = 1'b1;
      next_r.awaddr = awaddr_in;
    end
    if (wvalid_in && r.wready) begin
      next_r.w_have = 1'b1;
      next_r.wdat = wdata_in;
      next_r.wstrb = wstrb_in;
    end
    if (r.bvalid && bready_in) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_have && r.w_have && !r.bvalid) begin
      next_r.aw_have = 1'b0;
      next_r.w_have = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = `PBBP_RESP_OKAY;
      unique case (r.awaddr)
        `PBBP_REG_CTRL: begin
          if (r.wstrb[0]) begin
            next_r.go = r.go | r.wdat[`PBBP_CTRL_GO];
            next_r.dir = r.wdat[`PBBP_CTRL_WRITE];
            next_r.sleep_req = r.sleep_req | r.wdat[`PBBP_CTRL_SLEEP];
          end
        end
        `PBBP_REG_CONFIG: next_r.cfg = merge16(r.cfg, r.wdat, r.wstrb);
        `PBBP_REG_ADDR: next_r.addr = merge16(r.addr, r.wdat, r.wstrb);
        `PBBP_REG_WDATA: next_r.wdata = merge16(r.wdata, r.wdat, r.wstrb);
        `PBBP_REG_STATUS: begin
          if (r.wstrb[0]) begin
            next_r.row_stop = r.row_stop & ~r.wdat[`PBBP_ST_ROW];
            next_r.time_stop = r.time_stop & ~r.wdat[`PBBP_ST_TIME];
          end
        end
        default: next_r.bresp = `PBBP_RESP_SLVERR;
      endcase
    end
    next_r.awready = ~next_r.aw_have & ~next_r.bvalid;
    next_r.wready = ~next_r.w_have & ~next_r.bvalid;

    // register reads; a read of the data word pops the buffer
    if (r.rvalid && rready_in) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
    if (arvalid_in && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = `PBBP_RESP_OKAY;
      next_r.rdata = 32'h00000000;
      unique case (araddr_in)
        `PBBP_REG_CTRL: next_r.rdata[2:0] = {r.sleep_req, r.dir, r.go};
        `PBBP_REG_CONFIG: next_r.rdata[15:0] = r.cfg;
        `PBBP_REG_ADDR: next_r.rdata[15:0] = r.addr;
        `PBBP_REG_WDATA: next_r.rdata[15:0] = r.wdata;
        `PBBP_REG_RDATA: begin
          if (r.fcnt != 2'h0) begin
            next_r.rdata[15:0] = r.fifo[0];
            next_r.fifo[0] = r.fifo[1];
            next_r.fcnt = r.fcnt - 2'h1;
          end
        end
        `PBBP_REG_STATUS: begin
          next_r.rdata[6:0] = {r.state == pbbp_pkg::CTL_SLEEP,
            r.time_stop, r.row_stop, r.fcnt,
            r.state != pbbp_pkg::CTL_PWR,
            (r.state != pbbp_pkg::CTL_IDLE) | r.go};
        end
        default: next_r.rresp = `PBBP_RESP_SLVERR;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // link clock: eight clk cycles per period; held low while a read burst
    // has the buffer full, until select low nears its limit, so the memory cannot outrun software
    near = r.low_cnt >= 8'(`PBBP_MAX_LOW_CYC - `PBBP_LOW_MARGIN);
    stall = (r.state == pbbp_pkg::CTL_BURST) && !r.dir &&
      (next_r.fcnt == 2'h2) && !near;
    step = (r.div == `PBBP_DIV_STEP) && !stall;
    if (!(r.div == `PBBP_DIV_STEP && stall)) begin
      next_r.div = r.div + 3'h1;
    end
    next_r.link_clk = next_r.div[2];
    next_r.low_cnt = r.sel_n ? 8'h00 : r.low_cnt + 8'h01;
    // k names the link rise that follows this step
    k = r.step_c + 4'h1;
    // code 0 acts as code 1, as the memory end does
    first = (r.cfg[`PBBP_LC_HI:`PBBP_LC_LO] == 3'h0) ? 4'h2 :
      {1'b0, r.cfg[`PBBP_LC_HI:`PBBP_LC_LO]} + 4'h1;

    unique case (r.state)
      pbbp_pkg::CTL_PWR: begin
        next_r.tmr = r.tmr + 12'h001;
        if (r.tmr == 12'(`PBBP_PU_CYC - 1)) begin
          next_r.state = pbbp_pkg::CTL_IDLE;
          next_r.tmr = 12'h000;
        end
      end
      pbbp_pkg::CTL_IDLE: begin
        if (step && r.sleep_req) begin
          next_r.sleep_req = 1'b0;
          next_r.state = pbbp_pkg::CTL_SLEEP;
          next_r.tmr = 12'h000;
        end else if (step && r.go) begin
          next_r.go = 1'b0;
          next_r.state = pbbp_pkg::CTL_BURST;
          next_r.sel_n = 1'b0;
          next_r.adv_n = 1'b0;
          next_r.we_n = ~r.dir;
          next_r.dq = r.addr;
          next_r.dq_oe = 1'b1;
          next_r.step_c = 4'h0;
          next_r.words = 3'h0;
        end
      end
      pbbp_pkg::CTL_BURST: begin
        if (step) begin
          next_r.step_c = k;
          next_r.adv_n = 1'b1;
          next_r.oe_n = r.dir;
          next_r.dq_oe = r.dir;
          if (near) begin
            stop = 1'b1;
            next_r.time_stop = 1'b1;
          end else if (k >= first) begin
            if (!r.wait_s[1]) begin
              // wait mid-burst means row end: leave before next rise
              stop = 1'b1;
              next_r.row_stop = 1'b1;
            end else if (r.dir) begin
              if (r.words == `PBBP_BURST_LEN) begin
                stop = 1'b1;
              end else begin
                next_r.dq = r.wdata + {13'h0000, r.words};
                next_r.words = r.words + 3'h1;
              end
            end else begin
              next_r.fifo[next_r.fcnt[0]] = r.dqin_s[1];
              next_r.fcnt = next_r.fcnt + 2'h1;
              next_r.words = r.words + 3'h1;
              if (r.words + 3'h1 == `PBBP_BURST_LEN) begin
                stop = 1'b1;
              end
            end
          end
          if (stop) begin
            next_r.state = pbbp_pkg::CTL_GAP;
            next_r.sel_n = 1'b1;
            next_r.oe_n = 1'b1;
            next_r.we_n = 1'b1;
            next_r.dq_oe = 1'b0;
          end
        end
      end
      pbbp_pkg::CTL_GAP: begin
        // one full link period with select high before any new access
        if (step) begin
          next_r.state = pbbp_pkg::CTL_IDLE;
        end
      end
      pbbp_pkg::CTL_SLEEP: begin
        next_r.tmr = r.tmr + 12'h001;
        if (r.tmr == 12'(`PBBP_DPD_CYC + `PBBP_DPDX_CYC - 1)) begin
          next_r.state = pbbp_pkg::CTL_IDLE;
          next_r.tmr = 12'h000;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      r <= '0;
      r.state <= pbbp_pkg::CTL_PWR;
      r.sel_n <= 1'b1;
      r.adv_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.we_n <= 1'b1;
      r.wait_s <= 2'h3;
      r.cfg <= `PBBP_CFG_RESET;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
endmodule

// [pbbp_chk.sv]
// concurrent checks on the wires between the two link ends
`timescale 1ns/10ps
module pbbp_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // link signals and configuration image
  input wire logic link_clk,
  input wire logic select_n,
  input wire logic address_valid_n,
  input wire logic output_en_n,
  input wire logic ctl_dq_oe,
  input wire logic wait_n,
  input wire logic dev_dq_oe,
  input wire logic [15:0] config_out
);
  logic link_q;
  logic rise;
  logic [3:0] rises;
  logic [3:0] lc;
  logic [6:0] low_c;
  // code 0 behaves as code 1
  assign lc = (config_out[13:11] == 3'h0) ? 4'h1 : {1'b0, config_out[13:11]};
  assign rise = link_clk && !link_q;
  // rises: link clock rises seen so far inside the current select low
  always_ff @(posedge clk_in) begin
    link_q <= reset_in ? 1'b0 : link_clk;
    if (reset_in || select_n) begin
      rises <= 4'h0;
      low_c <= 7'h00;
    end else begin
      low_c <= (low_c == 7'h7F) ? low_c : low_c + 7'h01;
      if (rise && rises != 4'hF) begin
        rises <= rises + 4'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_sel_rise;
    rise && !select_n;
  endsequence
  sequence s_gap;
    select_n [*8];
  endsequence
  chk_lat_wait: assert property (
    s_sel_rise and (rises >= 4'h1 && rises <= lc) |-> !wait_n)
    else $error("wait released inside initial latency");
  chk_lat_end: assert property (
    s_sel_rise and (rises == lc + 4'h1) |-> wait_n)
    else $error("wait still low after initial latency");
  chk_addr_phase: assert property (
    s_sel_rise and (rises == 4'h0) |-> !address_valid_n && ctl_dq_oe)
    else $error("no address phase at first link rise");
  chk_burst_len: assert property (
    s_sel_rise |-> rises <= lc + 4'h4)
    else $error("select low past the last burst word");
  chk_gap_high: assert property ($rose(select_n) |-> s_gap)
    else $error("select high gap shorter than one link period");
  chk_low_limit: assert property (!select_n |-> low_c < 7'h64)
    else $error("select low longer than four microseconds");
  chk_wait_release: assert property (
    $rose(select_n) |-> ##[0:16] wait_n)
    else $error("wait held after select release");
  chk_dev_drive: assert property (
    $rose(dev_dq_oe) |-> !select_n && !output_en_n)
    else $error("memory drives the bus while not read selected");
endmodule

// [pbbp_tb_top.sv]
// self-checking bench: both link ends joined, axi4-lite stimulus
`timescale 1ns/10ps
`include "pbbp_defines.svh"
module pbbp_tb_top;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dev_busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] cfg;
  int errors = 0;
  int cmp_count = 0;
  pbbp_if link_if ();
  pbbp_ctrl pbbp_ctrl_inst (.clk_in(clk_in), .reset_in(reset_in),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
    .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
    .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
    .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
    .rvalid_out(rvalid), .rready_in(rready), .config_out(cfg),
    .link(link_if.ctl));
  pbbp_device pbbp_device_inst (.clk_in(clk_in), .reset_in(reset_in),
    .link(link_if.dev), .bus_config_in(cfg), .busy_out(dev_busy));
  pbbp_chk pbbp_chk_inst (.clk_in(clk_in), .reset_in(reset_in),
    .link_clk(link_if.link_clk), .select_n(link_if.select_n),
    .address_valid_n(link_if.address_valid_n),
    .output_en_n(link_if.output_en_n), .ctl_dq_oe(link_if.ctl_dq_oe),
    .wait_n(link_if.wait_n), .dev_dq_oe(link_if.dev_dq_oe),
    .config_out(cfg));
  always #20 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'h3;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_in);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk_in);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_in);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] r;
    wr(a, v, r);
    check({30'h0, r}, 32'h0);
  endtask
  // bounded wait on one status bit, polled over the register bus
  task automatic poll(input int b, input logic v);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    rd(`PBBP_REG_STATUS, d, r);
    while (d[b] !== v && n < 3000) begin
      rd(`PBBP_REG_STATUS, d, r);
      n++;
    end
    if (n == 3000) errors++;
  endtask
  // write burst then read it back, waiting for a full buffer before each read but the last
  task automatic burst_chk(input logic [5:0] a, input logic [15:0] wd,
                           input int cnt);
    logic [31:0] d;
    logic [1:0] r;
    reg_wr(`PBBP_REG_ADDR, {26'h0, a});
    reg_wr(`PBBP_REG_WDATA, {16'h0, wd});
    reg_wr(`PBBP_REG_CTRL, 32'h3);
    poll(0, 1'b0);
    reg_wr(`PBBP_REG_CTRL, 32'h1);
    for (int n = 0; n < cnt; n++) begin
      poll((n == cnt - 1) ? 2 : 3, 1'b1);
      rd(`PBBP_REG_RDATA, d, r);
      check(d, {16'h0, wd + 16'(n)});
    end
    poll(0, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] wd;
    logic [5:0] a;
    void'($urandom(84));
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    check({16'h0, cfg}, 32'h1000);
    rd(`PBBP_REG_CONFIG, d, r);
    check(d, 32'h1000);
    rd(8'h20, d, r);
    check({r, d[29:0]}, {`PBBP_RESP_SLVERR, 30'h0});
    wr(8'h24, 32'h1, r);
    check({30'h0, r}, {30'h0, `PBBP_RESP_SLVERR});
    poll(1, 1'b1);
    for (int c = 1; c <= 4; c++) begin
      reg_wr(`PBBP_REG_CONFIG, 32'(c) << 11);
      check({16'h0, cfg}, 32'(c) << 11);
      a = {2'($urandom), 4'($urandom % 13)};
      wd = 16'($urandom);
      burst_chk(a, wd, 4);
      rd(`PBBP_REG_STATUS, d, r);
      check({30'h0, d[5:4]}, 32'h0);
      check({31'h0, dev_busy}, 32'h0);
    end
    // buffer left full: link stalls until select low limit aborts
    reg_wr(`PBBP_REG_CTRL, 32'h1);
    poll(0, 1'b0);
    rd(`PBBP_REG_STATUS, d, r);
    check({28'h0, d[5:2]}, 32'hA);
    reg_wr(`PBBP_REG_STATUS, 32'h20);
    for (int n = 0; n < 2; n++) begin
      rd(`PBBP_REG_RDATA, d, r);
      check(d, {16'h0, wd + 16'(n)});
    end
    rd(`PBBP_REG_RDATA, d, r);
    check(d, 32'h0);
    rd(`PBBP_REG_STATUS, d, r);
    check({30'h0, d[5:4]}, 32'h0);
    // two words before the row end, then the crossing stops the burst
    burst_chk(6'h1E, 16'($urandom), 2);
    rd(`PBBP_REG_STATUS, d, r);
    check({31'h0, d[4]}, 32'h1);
    reg_wr(`PBBP_REG_STATUS, 32'h10);
    rd(`PBBP_REG_STATUS, d, r);
    check({31'h0, d[4]}, 32'h0);
    reg_wr(`PBBP_REG_CTRL, 32'h4);
    // sleep starts only at the next link step
    poll(6, 1'b1);
    rd(`PBBP_REG_STATUS, d, r);
    check({31'h0, d[6]}, 32'h1);
    poll(6, 1'b0);
    burst_chk(6'h20, 16'hFFFE, 4);
    check({31'h0, dev_busy}, 32'h0);
    complete_run();
  end
  initial begin
    #2400000;
    errors++;
    complete_run();
  end
endmodule
